// ### src/sup_timer.sv
// Supervision timer with interrupt, system reset and timed configuration lock
//
// How it works
// [RULE1] Counter ticks from divided oscillator enable
// [RULE2] Restart strobe zeroes counter; software restarts early
// [RULE3] Expiry issues interrupt or reset by mode
// [RULE4] Interrupt mode: expiry raises interrupt only
// [RULE5] Interrupt request also drives wake output
// [RULE6] Reset mode: expiry asserts system reset
// [RULE7] Combined mode: interrupt first, then reset mode
// [RULE8] Always-on fuse forces reset-only mode
// [RULE9] Fuse: reset enable reads 1, irq 0
// [RULE10] Clear reset or prescale needs opening write
// [RULE11] Setting write must land within four cycles
// [RULE12] Timer stays enabled after its own reset
// [RULE13] Software clears reset flag and enable
// [RULE14] Software restarts before shortening prescale
// [RULE15] Prescale field bits 5 and 2..0
// [RULE16] Codes 0..9: 2048 shl code cycles
// [RULE17] Window lapses: change enable self-clears
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module sup_timer
  import sup_pkg::*;
#(
  parameter int unsigned TICK_DIV  = OSC_TICK_CYCLES, // Clocks per oscillator cycle
  parameter int unsigned BASE_CNT  = BASE_TIMEOUT     // Oscillator cycles at code 0
) (
  input  wire logic     clk_sys,        // System clock, 100 MHz
  input  wire logic     rst_n,          // Power-on reset, async, active low
  input  wire sup_req_s req,            // Register bus request
  output logic [7:0]    rdata,          // Read data, cycle after read strobe
  input  wire logic     restart,        // Restart instruction strobe
  input  wire logic     always_on_fuse, // Fuse programmed: reset-only mode
  output logic          timeout_irq,    // Interrupt request to core
  output logic          wake_req,       // Wake from sleep request
  output logic          sys_reset       // One-cycle system reset request
);

  logic [15:0] div_cnt;
  logic        osc_tick;
  logic [19:0] cnt;
  logic [20:0] timeout_len;
  logic        expire;
  logic [3:0]  timeout_prescale_select;
  logic        reset_enable_bit;
  logic        timeout_irq_enable_bit;
  logic        change_enable_bit;
  logic [2:0]  win_cnt;
  logic        irq_flag;
  logic        timeout_reset_flag;
  logic        eff_re;
  logic        eff_ie;
  logic        running;
  logic        ctrl_wr;
  logic        stat_wr;
  logic [3:0]  wr_ps;
  logic [3:0]  ps_eff;

  // Decoded writes and written prescale code
  assign ctrl_wr = req.wr && (req.addr == ADDR_CTRL);
  assign stat_wr = req.wr && (req.addr == ADDR_STAT);
  assign wr_ps   = {req.wdata[CTRL_PS_HI], req.wdata[CTRL_PS_LO +: 3]}; // [RULE15]

  // Fuse overrides software mode bits
  assign eff_re  = reset_enable_bit | always_on_fuse;          // [RULE8] [RULE9]
  assign eff_ie  = timeout_irq_enable_bit & ~always_on_fuse;   // [RULE9]
  assign running = eff_re | eff_ie;

  // Oscillator cycle enable; slow clock modelled as a divided enable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt  <= 16'h0000;
      osc_tick <= 1'b0;
    end else if (div_cnt == 16'(TICK_DIV - 1)) begin
      div_cnt  <= 16'h0000;
      osc_tick <= 1'b1;                                         // [RULE1]
    end else begin
      div_cnt  <= div_cnt + 16'h0001;
      osc_tick <= 1'b0;
    end
  end

  // Reserved codes fall back to the longest period, never shorter
  assign ps_eff      = (timeout_prescale_select > PS_LAST_VALID) ?
                       PS_LAST_VALID : timeout_prescale_select;
  assign timeout_len = 21'(BASE_CNT) << ps_eff;                // [RULE16]
  assign expire      = running && osc_tick && !restart &&
                       ({1'b0, cnt} == timeout_len - 21'h000001); // [RULE3]

  // Oscillator cycle counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 20'h00000;
    end else if (restart || !running || expire) begin
      cnt <= 20'h00000;                                         // [RULE2]
    end else if (osc_tick) begin
      cnt <= cnt + 20'h00001;                                   // [RULE1]
    end
  end

  // Timed change window: opened by writing change and reset enable as one
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      change_enable_bit <= 1'b0;
      win_cnt           <= 3'h0;
    end else if (ctrl_wr && req.wdata[CTRL_CE] && req.wdata[CTRL_RE]
                 && !change_enable_bit) begin
      change_enable_bit <= 1'b1;                                // [RULE10]
      win_cnt           <= 3'(WIN_CYCLES);
    end else if (ctrl_wr && change_enable_bit) begin
      change_enable_bit <= 1'b0;                                // [RULE10]
      win_cnt           <= 3'h0;
    end else if (win_cnt != 3'h0) begin
      win_cnt <= win_cnt - 3'h1;                                // [RULE11]
      if (win_cnt == 3'h1) begin
        change_enable_bit <= 1'b0;                              // [RULE17]
      end
    end
  end

  // Reset enable and prescale; not cleared by the system reset we issue
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reset_enable_bit        <= RE_RESET;
      timeout_prescale_select <= PS_RESET;
    end else if (ctrl_wr) begin
      if (change_enable_bit) begin
        reset_enable_bit        <= req.wdata[CTRL_RE];          // [RULE10] [RULE11]
        timeout_prescale_select <= wr_ps;                       // [RULE15]
      end else if (req.wdata[CTRL_RE]) begin
        reset_enable_bit <= 1'b1;                               // Setting needs no sequence
      end
    end
  end

  // Interrupt enable; combined mode drops it at first expiry
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timeout_irq_enable_bit <= IE_RESET;
    end else if (expire && eff_ie && eff_re) begin
      timeout_irq_enable_bit <= 1'b0;                           // [RULE7]
    end else if (ctrl_wr) begin
      timeout_irq_enable_bit <= req.wdata[CTRL_IRQ_EN];
    end
  end

  // Sticky interrupt flag; set beats a same-cycle write-one clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_flag <= 1'b0;
    end else if (expire && eff_ie) begin
      irq_flag <= 1'b1;                                         // [RULE4] [RULE7]
    end else if (ctrl_wr && req.wdata[CTRL_IRQ_FLAG]) begin
      irq_flag <= 1'b0;
    end
  end

  // System reset pulse and its sticky flag; software clears flag by writing 0
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sys_reset          <= 1'b0;
      timeout_reset_flag <= 1'b0;
    end else begin
      sys_reset <= expire && eff_re && !eff_ie;                 // [RULE6] [RULE12]
      if (expire && eff_re && !eff_ie) begin
        timeout_reset_flag <= 1'b1;                             // [RULE6]
      end else if (stat_wr && !req.wdata[STAT_RST_FLAG]) begin
        timeout_reset_flag <= 1'b0;
      end
    end
  end

  // Interrupt and wake are the pending flag; works with no other clock
  assign timeout_irq = irq_flag;                                // [RULE4]
  assign wake_req    = irq_flag;                                // [RULE5]

  // Read port, data one cycle after the strobe; fuse forces mode bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (req.rd && req.addr == ADDR_CTRL) begin
      rdata <= {irq_flag, eff_ie, timeout_prescale_select[3], change_enable_bit,
                eff_re, timeout_prescale_select[2:0]};          // [RULE9]
    end else if (req.rd && req.addr == ADDR_STAT) begin
      rdata <= {4'h0, timeout_reset_flag, 3'h0};
    end else begin
      rdata <= 8'h00;                                           // Unmapped and idle read 0
    end
  end

endmodule // sup_timer

`default_nettype wire

// ### src/sup_pkg.sv
// Package for the supervision timer: map, fields, timing constants and bus types
package sup_pkg;

  // Clock and oscillator rates
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned OSC_HZ           = 128_000;
  localparam int unsigned OSC_TICK_CYCLES  = CLK_HZ / OSC_HZ;
  localparam int unsigned BASE_TIMEOUT     = 2048;
  localparam int unsigned WIN_CYCLES       = 4;

  // Register offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;

  // Control register field positions
  localparam int unsigned CTRL_IRQ_FLAG = 7;
  localparam int unsigned CTRL_IRQ_EN   = 6;
  localparam int unsigned CTRL_PS_HI    = 5;
  localparam int unsigned CTRL_CE       = 4;
  localparam int unsigned CTRL_RE       = 3;
  localparam int unsigned CTRL_PS_LO    = 0;

  // Status register field positions
  localparam int unsigned STAT_RST_FLAG = 3;

  // Reset values
  localparam logic [3:0] PS_RESET      = 4'h0;
  localparam logic       RE_RESET      = 1'b0;
  localparam logic       IE_RESET      = 1'b0;
  localparam logic [3:0] PS_LAST_VALID = 4'h9;

  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sup_req_s;

endpackage

// ### bench/sup_timer_checker.sv
// Concurrent checks on the supervision timer ports
`timescale 1ns/1ps
`default_nettype none
module sup_checker
  import sup_pkg::*;
(
  input wire logic       clk_sys,        // System clock
  input wire logic       rst_n,          // Async reset, active low
  input wire sup_req_s   req,            // Register bus request
  input wire logic [7:0] rdata,          // Read data
  input wire logic       restart,        // Restart strobe
  input wire logic       always_on_fuse, // Fuse level
  input wire logic       timeout_irq,    // Interrupt request
  input wire logic       wake_req,       // Wake request
  input wire logic       sys_reset       // Reset pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_wake_tracks_irq: assert property (wake_req == timeout_irq)
    else $error("wake request differs from interrupt");
  a_reset_one_cycle: assert property (sys_reset |=> !sys_reset)
    else $error("reset pulse longer than one cycle");
  a_expiry_gap_min: assert property ($rose(sys_reset) |=> !sys_reset [*6])
    else $error("reset pulses closer than the shortest time-out");
  a_restart_stops_irq: assert property (restart |=> !$rose(timeout_irq))
    else $error("interrupt rose right after restart");
  a_restart_stops_rst: assert property (restart |-> ##2 !sys_reset)
    else $error("reset pulse right after restart");
  a_fuse_no_irq: assert property (always_on_fuse && $past(always_on_fuse, 2)
    |-> !$rose(timeout_irq))
    else $error("interrupt rose with fuse programmed");
  a_fuse_read_lock: assert property (always_on_fuse && req.rd && req.addr == ADDR_CTRL
    |=> rdata[CTRL_RE] && !rdata[CTRL_IRQ_EN])
    else $error("fuse-locked bits read wrong");
  a_irq_not_reset: assert property ($rose(timeout_irq) |-> !sys_reset)
    else $error("interrupt and reset at one expiry");
  c_irq: cover property ($rose(timeout_irq));
  c_reset: cover property (sys_reset);
  c_fuse_read: cover property (always_on_fuse && req.rd);
endmodule // sup_checker
bind sup_timer sup_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
  .rdata(rdata), .restart(restart), .always_on_fuse(always_on_fuse),
  .timeout_irq(timeout_irq), .wake_req(wake_req), .sys_reset(sys_reset));
`default_nettype wire

// ### bench/tb_sup_timer.sv
// Self-checking bench for the supervision timer
`timescale 1ns/1ps
`default_nettype none
module tb_sup_timer;
  import sup_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, restart = 1'b0, always_on_fuse = 1'b0;
  sup_req_s req = '0;
  logic [7:0] rdata;
  logic timeout_irq, wake_req, sys_reset;
  int err_total = 0, cmp_count = 0, cyc = 0, k;
  // Short divider and base count keep the longest time-out near 4096 clocks
  sup_timer #(.TICK_DIV(2), .BASE_CNT(4)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .req(req), .rdata(rdata), .restart(restart), .always_on_fuse(always_on_fuse),
    .timeout_irq(timeout_irq), .wake_req(wake_req), .sys_reset(sys_reset));
  always #5 clk_sys = ~clk_sys;
  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Mismatches %0d, comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys) req <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys) req <= '0;
    #1 chk(rdata, e);
  endtask
  // Counts clocks until the chosen output goes high, n at most
  task automatic wait_for(input int n, input bit on_rst, output int c);
    for (c = 0; c < n; c++) begin
      @(posedge clk_sys) #1;
      if ((on_rst ? sys_reset : timeout_irq) === 1'b1) break;
    end
  endtask
  // Restart pulse before any prescale change
  task automatic kick();
    @(posedge clk_sys) restart <= 1'b1;
    @(posedge clk_sys) restart <= 1'b0;
  endtask
  task automatic t_irq();
    wr(ADDR_CTRL, 8'h40);
    wait_for(40, 1'b0, k);
    chk(8'(k < 40), 8'h01);
    chk(8'(sys_reset), 8'h00);
    wr(ADDR_CTRL, 8'h80);
    #1 chk(8'(timeout_irq), 8'h00);
  endtask
  task automatic t_restart();
    wr(ADDR_CTRL, 8'h40);
    repeat (12) begin
      @(posedge clk_sys) restart <= 1'b1;
      @(posedge clk_sys) restart <= 1'b0;
      @(posedge clk_sys);
      #1 chk(8'(timeout_irq), 8'h00);
    end
    wr(ADDR_CTRL, 8'h00);
  endtask
  task automatic t_combined();
    wr(ADDR_CTRL, 8'h48);
    wait_for(40, 1'b0, k);
    chk(8'(k < 40), 8'h01);
    wait_for(40, 1'b1, k);
    chk(8'(k < 40), 8'h01);
    rd(ADDR_CTRL, 8'h88);
    rd(ADDR_STAT, 8'h08);
    // Initialisation: clear reset flag, then reset enable
    wr(ADDR_STAT, 8'h00);
    wr(ADDR_CTRL, 8'h18);
    wr(ADDR_CTRL, 8'h80);
    rd(ADDR_CTRL, 8'h00);
  endtask
  task automatic t_timed();
    kick();
    wr(ADDR_CTRL, 8'h18);
    wr(ADDR_CTRL, 8'h0D);
    rd(ADDR_CTRL, 8'h0D);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, 8'h0D);
    wr(ADDR_CTRL, 8'h18);
    repeat (5) @(posedge clk_sys);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, 8'h0D);
    // Code 5 gives 4 shl 5 ticks of 2 clocks each
    kick();
    wait_for(300, 1'b1, k);
    chk(8'(k > 240 && k < 270), 8'h01);
    kick();
    wr(ADDR_CTRL, 8'h18);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, 8'h00);
  endtask
  task automatic t_fuse();
    @(posedge clk_sys) always_on_fuse <= 1'b1;
    wr(ADDR_CTRL, 8'h40);
    rd(ADDR_CTRL, 8'h08);
    wait_for(40, 1'b1, k);
    chk(8'(k < 40), 8'h01);
    @(posedge clk_sys) always_on_fuse <= 1'b0;
    wr(ADDR_CTRL, 8'h18);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(ADDR_CTRL, 8'h00);
    rd(ADDR_STAT, 8'h00);
    rd(4'hF, 8'h00);
    t_irq();
    t_restart();
    t_combined();
    t_timed();
    t_fuse();
    complete_run();
  end
endmodule // tb_sup_timer
`default_nettype wire
